/* File: rtl/etc_pkg.sv */
// Purpose: Shared constants and types of the echo test channel control.
// Assumes: 8-bit register port, 25 MHz clock, 125 us frame.
// Notes:   Control and generator registers travel as packed structs.
package etc_pkg;

   // Register offsets on the byte-wide register port
   localparam logic [7:0] ADDR_CHAN_SEL = 8'h35;
   localparam logic [7:0] ADDR_TEST_EN = 8'h37;
   localparam logic [7:0] ADDR_CTRL = 8'h38;
   localparam logic [7:0] ADDR_SEND_GEN = 8'h39;
   localparam logic [7:0] ADDR_RECV_GEN = 8'h3a;
   localparam logic [7:0] ADDR_STATUS = 8'h3d;

   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] GEN_RST = 8'h55;
   localparam logic [4:0] CHAN_RST = 5'h00;

   // Field positions
   localparam int STE_BIT = 1;
   localparam int ABORT_BIT = 0;
   localparam int RUN_BIT = 1;
   localparam int CHAN_W = 5;

   // Timing
   localparam int CLK_HZ = 25_000_000;
   localparam int FRAME_US = 125;
   localparam int FRAME_CYC = FRAME_US * (CLK_HZ / 1_000_000);
   localparam int TONE_HI_HZ = 2105;
   localparam int TONE_LO_HZ = 2010;
   localparam logic [2:0] END_DELAY_BASE = 3'h4;

   // Random sign source
   localparam logic [14:0] LFSR_SEED = 15'h0001;

   // Control register layout, MSB first
   typedef struct packed {
      logic hold;
      logic nlp_bypass;
      logic atten_off;
      logic silence_off;
      logic chan_on;
      logic alaw;
      logic [1:0] end_delay;
   } etc_ctrl_t;

   // Generator register layout
   typedef struct packed {
      logic mode;
      logic [6:0] amp;
   } etc_gen_t;

   // Background test session
   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_ABORT} etc_state_t;

endpackage : etc_pkg

/* File: rtl/etc_sign_gen.sv */
// Purpose: Sign sequence source of the test signal generator.
// Assumes: frame_tick_i pulses once per 125 us frame.
// Notes:   Tones are phase accumulators stepped per frame; random is LFSR.
`timescale 1ns/1ps
module etc_sign_gen #(
   parameter int ACC_W = 24
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic frame_tick_i,
   input wire logic [1:0] mode_i,
   output logic sign_o
);

   // Phase step per frame for a square wave of the given frequency
   function automatic logic [ACC_W-1:0] phase_step(input int hz);
      longint s;
      s = (longint'(hz) << ACC_W) /
          longint'(etc_pkg::CLK_HZ / etc_pkg::FRAME_CYC);
      return s[ACC_W-1:0];
   endfunction : phase_step

   localparam logic [ACC_W-1:0] STEP_HI = phase_step(etc_pkg::TONE_HI_HZ);
   localparam logic [ACC_W-1:0] STEP_LO = phase_step(etc_pkg::TONE_LO_HZ);

   generate
      if (ACC_W < 16) begin : g_bad_w
         $error("etc_sign_gen: ACC_W too small for tone resolution");
      end
   endgenerate

   logic [ACC_W-1:0] acc_hi_r;
   logic [ACC_W-1:0] acc_lo_r;
   logic [14:0] lfsr_r;

   // Tones step once a frame, so their rate holds in sample time
   // whatever frame length the top is built with
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acc_hi_r <= '0;
         acc_lo_r <= '0;
      end else if (frame_tick_i) begin
         acc_hi_r <= acc_hi_r + STEP_HI;
         acc_lo_r <= acc_lo_r + STEP_LO;
      end
   end

   // Random source steps once a frame, one new sign per sample
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lfsr_r <= etc_pkg::LFSR_SEED;
      end else if (frame_tick_i) begin
         lfsr_r <= {lfsr_r[13:0], lfsr_r[14] ^ lfsr_r[13]};
      end
   end

   // Sign is sampled at the frame so one sample has one sign
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sign_o <= 1'b0;
      end else if (frame_tick_i) begin
         unique case (mode_i)
            2'b00: sign_o <= acc_hi_r[ACC_W-1];
            2'b01: sign_o <= ~acc_hi_r[ACC_W-1];
            2'b10: sign_o <= acc_lo_r[ACC_W-1];
            2'b11: sign_o <= lfsr_r[0];
         endcase
      end
   end

   chk_lfsr_alive: assert property (@(posedge clk_i)
      disable iff (!rst_n_i) lfsr_r != '0)
      else $error("random sign source locked up");

endmodule : etc_sign_gen

/* File: rtl/etc_top.sv */
// Purpose: Register control of one background-tested echo channel and
//          its rectified test pattern generator.
// Assumes: Register port strobes are one cycle; read data next cycle.
// Notes:   All outputs are registered; effective controls lag by one.
// Behaviour
// - Freeze bit holds speech control and coefficients.
// - Bypass bit disables nonlinear processor.
// - Attenuator off bit, else follow PCM configuration.
// - Silence detect off bit disables no-speech detection.
// - Channel off disables and clears coefficients, meters.
// - Law bit: one A-law, zero mu-law.
// - Under test, external controls are ignored.
// - Send generator: mode-high bit plus seven-bit amplitude.
// - Receive generator: mode-low bit plus seven-bit amplitude.
// - Rectified samples: path amplitude, mode-selected sign.
// - Mode bits pick 2105, inverted, 2010, random.
// - Self-test enable applies controls to addressed channel.
// - Test only disabled channel; external enable flags abort.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module etc_top #(
   parameter int FRAME_CYCLES = etc_pkg::FRAME_CYC
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire etc_pkg::etc_ctrl_t ext_ctrl_i,
   input wire logic pcm_atten_off_i,
   input wire logic ext_chan_enabled_i,
   output logic test_active_o,
   output logic [etc_pkg::CHAN_W-1:0] test_channel_o,
   output etc_pkg::etc_ctrl_t eff_ctrl_o,
   output logic coef_clear_o,
   output logic [2:0] end_delay_frames_o,
   output logic abort_req_o,
   output logic sample_valid_o,
   output logic [7:0] send_sample_o,
   output logic [7:0] recv_sample_o
);

   generate
      if (FRAME_CYCLES < 4 || FRAME_CYCLES > 65535) begin : g_bad_frame
         $error("etc_top: FRAME_CYCLES out of range");
      end
   endgenerate

   // Software-visible state
   etc_pkg::etc_ctrl_t ctrl_r;
   etc_pkg::etc_gen_t send_r;
   etc_pkg::etc_gen_t recv_r;
   logic ste_r;
   logic [etc_pkg::CHAN_W-1:0] chan_r;
   logic abort_flag_r;
   etc_pkg::etc_state_t state_r;
   etc_pkg::etc_state_t state_nxt;

   // Frame timing and sampling
   logic [15:0] frame_cnt_r;
   logic frame_tick;
   logic tick_d_r;
   logic sign;
   logic run;
   logic past_ok_r;

   // Register decode
   logic wr_ctrl;
   logic wr_send;
   logic wr_recv;
   logic wr_ste;
   logic wr_chan;
   logic wr_status;
   logic abort_event;

   assign wr_ctrl = wr_i && (addr_i == etc_pkg::ADDR_CTRL);
   assign wr_send = wr_i && (addr_i == etc_pkg::ADDR_SEND_GEN);
   assign wr_recv = wr_i && (addr_i == etc_pkg::ADDR_RECV_GEN);
   assign wr_ste = wr_i && (addr_i == etc_pkg::ADDR_TEST_EN);
   assign wr_chan = wr_i && (addr_i == etc_pkg::ADDR_CHAN_SEL);
   assign wr_status = wr_i && (addr_i == etc_pkg::ADDR_STATUS);
   assign run = (state_r == etc_pkg::ST_RUN);

   // Test channel control register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_r <= etc_pkg::CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_r <= wdata_i;
      end
   end

   // Generator registers; top bit is a mode bit, low seven amplitude
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         send_r <= etc_pkg::GEN_RST;
         recv_r <= etc_pkg::GEN_RST;
      end else begin
         if (wr_send) begin
            send_r <= wdata_i;
         end
         if (wr_recv) begin
            recv_r <= wdata_i;
         end
      end
   end

   // Self-test enable and channel address
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ste_r <= 1'b0;
         chan_r <= etc_pkg::CHAN_RST;
      end else begin
         if (wr_ste) begin
            ste_r <= wdata_i[etc_pkg::STE_BIT];
         end
         if (wr_chan) begin
            chan_r <= wdata_i[etc_pkg::CHAN_W-1:0];
         end
      end
   end

   // Session: a test may only start or stay in a disabled channel
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         etc_pkg::ST_IDLE: begin
            if (ste_r) begin
               state_nxt = ext_chan_enabled_i ? etc_pkg::ST_ABORT
                                              : etc_pkg::ST_RUN;
            end
         end
         etc_pkg::ST_RUN: begin
            if (!ste_r) begin
               state_nxt = etc_pkg::ST_IDLE;
            end else if (ext_chan_enabled_i) begin
               state_nxt = etc_pkg::ST_ABORT;
            end
         end
         etc_pkg::ST_ABORT: begin
            if (!ste_r) begin
               state_nxt = etc_pkg::ST_IDLE;
            end
         end
         default: state_nxt = etc_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= etc_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign abort_event = (state_r != etc_pkg::ST_ABORT) &&
                        (state_nxt == etc_pkg::ST_ABORT);

   // Sticky abort flag; a new abort wins over a write-one clear
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         abort_flag_r <= 1'b0;
      end else if (abort_event) begin
         abort_flag_r <= 1'b1;
      end else if (wr_status && wdata_i[etc_pkg::ABORT_BIT]) begin
         abort_flag_r <= 1'b0;
      end
   end

   // Read port: data in the cycle after the strobe, unmapped reads 0
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         unique case (addr_i)
            etc_pkg::ADDR_CTRL: rdata_o <= ctrl_r;
            etc_pkg::ADDR_SEND_GEN: rdata_o <= send_r;
            etc_pkg::ADDR_RECV_GEN: rdata_o <= recv_r;
            etc_pkg::ADDR_TEST_EN: rdata_o <= {6'h00, ste_r, 1'b0};
            etc_pkg::ADDR_CHAN_SEL: rdata_o <= {3'h0, chan_r};
            etc_pkg::ADDR_STATUS: rdata_o <= {6'h00, run, abort_flag_r};
            default: rdata_o <= 8'h00;
         endcase
      end else begin
         rdata_o <= 8'h00;
      end
   end

   // Control outputs: register values replace external ones under test
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         eff_ctrl_o <= etc_pkg::CTRL_RST;
         test_active_o <= 1'b0;
         test_channel_o <= etc_pkg::CHAN_RST;
         abort_req_o <= 1'b0;
      end else begin
         test_active_o <= run;
         test_channel_o <= chan_r;
         abort_req_o <= abort_flag_r;
         if (run) begin
            eff_ctrl_o.hold <= ctrl_r.hold;
            eff_ctrl_o.nlp_bypass <= ctrl_r.nlp_bypass;
            eff_ctrl_o.atten_off <= ctrl_r.atten_off |
                                    pcm_atten_off_i;
            eff_ctrl_o.silence_off <= ctrl_r.silence_off;
            eff_ctrl_o.chan_on <= ctrl_r.chan_on;
            eff_ctrl_o.alaw <= ctrl_r.alaw;
            eff_ctrl_o.end_delay <= ctrl_r.end_delay;
         end else begin
            eff_ctrl_o <= ext_ctrl_i;
         end
      end
   end

   // Channel off under test clears coefficients and attenuation meters
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         coef_clear_o <= 1'b0;
      end else begin
         coef_clear_o <= run && !ctrl_r.chan_on;
      end
   end

   // End delay in frames; field 0..3 maps onto 4..7 frames
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         end_delay_frames_o <= etc_pkg::END_DELAY_BASE;
      end else begin
         end_delay_frames_o <= etc_pkg::END_DELAY_BASE +
                               {1'b0, eff_nxt_delay()};
      end
   end

   function automatic logic [1:0] eff_nxt_delay();
      return run ? ctrl_r.end_delay : ext_ctrl_i.end_delay;
   endfunction : eff_nxt_delay

   // Frame counter gives the 8 kHz sample strobe
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         frame_cnt_r <= 16'h0000;
      end else if (frame_tick) begin
         frame_cnt_r <= 16'h0000;
      end else begin
         frame_cnt_r <= frame_cnt_r + 16'h0001;
      end
   end

   assign frame_tick = (frame_cnt_r == 16'(FRAME_CYCLES - 1));

   etc_sign_gen i_etc_sign_gen (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .frame_tick_i(frame_tick),
      .mode_i({send_r.mode, recv_r.mode}),
      .sign_o(sign)
   );

   // Samples are taken one cycle after the tick, once the sign settled
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tick_d_r <= 1'b0;
         sample_valid_o <= 1'b0;
         send_sample_o <= 8'h00;
         recv_sample_o <= 8'h00;
      end else begin
         tick_d_r <= frame_tick;
         sample_valid_o <= tick_d_r && run;
         if (tick_d_r && run) begin
            send_sample_o <= {sign, send_r.amp};
            recv_sample_o <= {sign, recv_r.amp};
         end
      end
   end

   // Helper so checks never look across the reset release
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         past_ok_r <= 1'b0;
      end else begin
         past_ok_r <= 1'b1;
      end
   end

   chk_freeze_pass: assert property (@(posedge clk_i)
      disable iff (!rst_n_i) past_ok_r && $past(run) |->
      eff_ctrl_o.hold == $past(ctrl_r.hold))
      else $error("hold output does not follow freeze bit");

   chk_nlp_pass: assert property (@(posedge clk_i)
      disable iff (!rst_n_i) past_ok_r && $past(run) |->
      eff_ctrl_o.nlp_bypass == $past(ctrl_r.nlp_bypass))
      else $error("bypass output does not follow bypass bit");

   chk_atten_rule: assert property (@(posedge clk_i)
      disable iff (!rst_n_i) past_ok_r && $past(run) |->
      eff_ctrl_o.atten_off ==
      ($past(ctrl_r.atten_off) || $past(pcm_atten_off_i)))
      else $error("attenuator output wrong under test");

   chk_silence_pass: assert property (@(posedge clk_i)
      disable iff (!rst_n_i) past_ok_r && $past(run) |->
      eff_ctrl_o.silence_off == $past(ctrl_r.silence_off))
      else $error("silence detect output wrong under test");

   chk_coef_clear: assert property (@(posedge clk_i)
      disable iff (!rst_n_i)
      run && !ctrl_r.chan_on |=> coef_clear_o && !eff_ctrl_o.chan_on)
      else $error("disabled test channel not cleared");

   // A write lands one edge before the output shows it, so compare
   // against the value the output was built from
   chk_law_pass: assert property (@(posedge clk_i)
      disable iff (!rst_n_i) run && $stable(ctrl_r) |=>
      eff_ctrl_o.alaw == $past(ctrl_r.alaw))
      else $error("law output does not follow law bit");

   chk_end_delay: assert property (@(posedge clk_i)
      disable iff (!rst_n_i) past_ok_r && $past(run) |->
      end_delay_frames_o == 3'($past(ctrl_r.end_delay) + 3'h4))
      else $error("end delay not four to seven frames");

   chk_ext_ignored: assert property (@(posedge clk_i)
      disable iff (!rst_n_i)
      run ##1 run && $changed(ext_ctrl_i) && $stable(ctrl_r) &&
      $stable(pcm_atten_off_i) |=> $stable(eff_ctrl_o))
      else $error("external control leaked into tested channel");

   chk_send_sample: assert property (@(posedge clk_i)
      disable iff (!rst_n_i)
      sample_valid_o |-> send_sample_o[6:0] == $past(send_r.amp) &&
      recv_sample_o[6:0] == $past(recv_r.amp) &&
      send_sample_o[7] == recv_sample_o[7])
      else $error("sample magnitude not from amplitude field");

   chk_sample_rate: assert property (@(posedge clk_i)
      disable iff (!rst_n_i) sample_valid_o |=> !sample_valid_o [*3])
      else $error("samples closer than one frame");

   chk_run_enable: assert property (@(posedge clk_i)
      disable iff (!rst_n_i) !ste_r |=> !run ##1 !test_active_o)
      else $error("test kept running without self-test enable");

   chk_abort_flag: assert property (@(posedge clk_i)
      disable iff (!rst_n_i) run && ste_r && ext_chan_enabled_i |=>
      abort_flag_r ##1 abort_req_o)
      else $error("external enable during test gave no abort");

   cov_run: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      !run ##1 run);
   cov_abort: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      run ##1 state_r == etc_pkg::ST_ABORT);
   cov_random: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      sample_valid_o && send_r.mode && recv_r.mode);
   cov_clear_race: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      abort_event && wr_status);

endmodule : etc_top

/* File: tb/echo_test_channel_control_bench.sv */
// Purpose: Self-checking bench for the echo test channel control block.
// Assumes: Short frame parameter so that many samples fit in one run.
// Notes:   Bus tasks drive on the rising edge; reads sample one cycle on.
`timescale 1ns/1ps
module echo_test_channel_control_bench;
   localparam int FRAMES = 8;
   localparam int NSAMP = 400;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] rdata_o;
   etc_pkg::etc_ctrl_t ext_ctrl_i = 8'h5a;
   logic pcm_atten_off_i = 1'b0;
   logic ext_chan_enabled_i = 1'b0;
   logic test_active_o;
   logic [etc_pkg::CHAN_W-1:0] test_channel_o;
   etc_pkg::etc_ctrl_t eff_ctrl_o;
   logic coef_clear_o;
   logic [2:0] end_delay_frames_o;
   logic abort_req_o;
   logic sample_valid_o;
   logic [7:0] send_sample_o;
   logic [7:0] recv_sample_o;
   int failures = 0;
   int checks_done = 0;
   logic [7:0] ctrl_tab [4] = '{8'hfc, 8'h01, 8'ha2, 8'h57};
   int flips;
   logic [7:0] rv;

   etc_top #(.FRAME_CYCLES(FRAMES)) i_etc_top (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_ctrl_i(ext_ctrl_i),
      .pcm_atten_off_i(pcm_atten_off_i),
      .ext_chan_enabled_i(ext_chan_enabled_i),
      .test_active_o(test_active_o), .test_channel_o(test_channel_o),
      .eff_ctrl_o(eff_ctrl_o), .coef_clear_o(coef_clear_o),
      .end_delay_frames_o(end_delay_frames_o), .abort_req_o(abort_req_o),
      .sample_valid_o(sample_valid_o), .send_sample_o(send_sample_o),
      .recv_sample_o(recv_sample_o)
   );

   // Free-running 25 MHz clock
   always #20 clk_i = ~clk_i;

   // Verdict and end of run, shared by the main flow and every timeout
   task wrap_up;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up

   task check(input logic [7:0] seen, input logic [7:0] exp,
              input string what);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t %s: saw %h want %h", $time, what, seen, exp);
      end
   endtask : check

   // One-cycle write strobe beside address and data
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr

   // Read strobe for one cycle; data stand only in the cycle after it
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      d = rdata_o;
   endtask : rd

   task rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      check(d, exp, "register read");
   endtask : rd_chk

   function automatic bit cond(input int w);
      case (w)
         0: return test_active_o === 1'b1;
         1: return test_active_o === 1'b0;
         2: return sample_valid_o === 1'b1;
         default: return abort_req_o === 1'b1;
      endcase
   endfunction : cond

   // Bounded wait; a wait that runs out ends the run as a failure
   task wait_sig(input int w, input int bound);
      int i;
      i = 0;
      while (!cond(w)) begin
         if (i == bound) begin
            failures++;
            $display("[FAIL] %0t wait %0d timed out", $time, w);
            wrap_up();
         end
         @(posedge clk_i);
         #1;
         i++;
      end
   endtask : wait_sig

   // Collect samples and count sign changes between neighbours
   task count_flips(input logic [6:0] sa, input logic [6:0] ra);
      logic prev;
      flips = 0;
      for (int k = 0; k < NSAMP; k++) begin
         @(posedge clk_i);
         #1;
         wait_sig(2, 4 * FRAMES);
         if (k > 0 && send_sample_o[7] !== prev) flips++;
         prev = send_sample_o[7];
      end
      check(send_sample_o[6:0], sa, "send amplitude");
      check(recv_sample_o[6:0], ra, "recv amplitude");
      check(recv_sample_o[7], send_sample_o[7], "shared sign");
   endtask : count_flips

   // Watchdog against a hang anywhere in the sequence
   initial begin
      #(40 * 100000);
      failures++;
      $display("[FAIL] %0t run limit reached", $time);
      wrap_up();
   end

   initial begin
      int lo;
      int hi;
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      // The release edge itself still sees reset; look one edge on
      @(posedge clk_i);
      #1;
      check(end_delay_frames_o, 8'd6, "idle delay");
      // Reset values, then an unmapped place
      rd_chk(etc_pkg::ADDR_CTRL, 8'h00);
      rd_chk(etc_pkg::ADDR_SEND_GEN, 8'h55);
      rd_chk(etc_pkg::ADDR_RECV_GEN, 8'h55);
      rd_chk(etc_pkg::ADDR_CHAN_SEL, 8'h00);
      rd_chk(etc_pkg::ADDR_TEST_EN, 8'h00);
      wr(8'h10, 8'hff);
      rd_chk(8'h10, 8'h00);
      check(eff_ctrl_o, 8'h5a, "idle passes external");
      // Channel address: only five bits exist
      wr(etc_pkg::ADDR_CHAN_SEL, 8'hff);
      rd_chk(etc_pkg::ADDR_CHAN_SEL, 8'h1f);
      check(8'(test_channel_o), 8'h1f, "test channel");
      // Write then read in the very next cycle
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= etc_pkg::ADDR_CTRL;
      wdata_i <= 8'hff;
      @(posedge clk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      check(rdata_o, 8'hff, "back to back read");
      @(posedge clk_i);
      #1;
      check(rdata_o, 8'h00, "read data one cycle only");
      // Start a background test in a disabled channel
      wr(etc_pkg::ADDR_TEST_EN, 8'h02);
      wait_sig(0, 10);
      rd_chk(etc_pkg::ADDR_STATUS, 8'h02);
      // Each control bit at one and at zero, external side opposite
      for (int i = 0; i < 4; i++) begin
         rv = ctrl_tab[i];
         ext_ctrl_i <= ~rv;
         wr(etc_pkg::ADDR_CTRL, rv);
         repeat (3) @(posedge clk_i);
         #1;
         check(eff_ctrl_o, rv, "ctl");
         check(coef_clear_o, !ctrl_tab[i][3], "coef clear");
         check(end_delay_frames_o, 3'd4 + ctrl_tab[i][1:0], "delay");
      end
      // Attenuator follows the PCM setting when its test bit is zero
      pcm_atten_off_i <= 1'b1;
      wr(etc_pkg::ADDR_CTRL, 8'h01);
      repeat (3) @(posedge clk_i);
      #1;
      check(eff_ctrl_o, 8'h21, "pcm attenuator");
      pcm_atten_off_i <= 1'b0;
      wr(etc_pkg::ADDR_CTRL, 8'h08);
      // Sign sequences for every mode; rate judged by flip count
      for (int m = 0; m < 4; m++) begin
         wr(etc_pkg::ADDR_SEND_GEN, {m[1], 7'h13 + 7'(m)});
         wr(etc_pkg::ADDR_RECV_GEN, {m[0], 7'h6c - 7'(m)});
         count_flips(7'h13 + 7'(m), 7'h6c - 7'(m));
         if (m < 2) begin
            lo = (2 * etc_pkg::TONE_HI_HZ * NSAMP) / 8000 - 3;
         end else if (m == 2) begin
            lo = (2 * etc_pkg::TONE_LO_HZ * NSAMP) / 8000 - 3;
         end else begin
            lo = NSAMP * 3 / 8;
         end
         hi = (m == 3) ? NSAMP * 5 / 8 : lo + 6;
         check(8'(flips >= lo && flips <= hi), 8'h01, "sign rate");
      end
      // External enable during the test forces an abort
      ext_ctrl_i <= 8'h33;
      ext_chan_enabled_i <= 1'b1;
      wait_sig(3, 10);
      wait_sig(1, 10);
      repeat (2) @(posedge clk_i);
      #1;
      check(eff_ctrl_o, 8'h33, "abort releases controls");
      rd_chk(etc_pkg::ADDR_STATUS, 8'h01);
      ext_chan_enabled_i <= 1'b0;
      wr(etc_pkg::ADDR_STATUS, 8'h01);
      rd_chk(etc_pkg::ADDR_STATUS, 8'h00);
      wr(etc_pkg::ADDR_TEST_EN, 8'h00);
      // No samples once the test is stopped
      repeat (4 * FRAMES) begin
         @(posedge clk_i);
         #1;
         check(sample_valid_o, 1'b0, "no samples idle");
      end
      // Start refused while the channel is externally enabled
      ext_chan_enabled_i <= 1'b1;
      wr(etc_pkg::ADDR_TEST_EN, 8'h02);
      wait_sig(3, 10);
      check(test_active_o, 1'b0, "refused start");
      wr(etc_pkg::ADDR_TEST_EN, 8'h00);
      wrap_up();
   end
endmodule : echo_test_channel_control_bench
